// file: mm_agent_pkg.sv
/*
  Shared constants and carrier types for the memory-mapped agent register bank.
  Assumes a single word-addressed agent port and a separate system clock domain.
*/
package mm_agent_pkg;

  // ----------------------------------------------------------------------
  // bus geometry defaults
  // ----------------------------------------------------------------------
  localparam int ADDR_W_DEF = 10;
  localparam int DATA_W_DEF = 16;
  localparam int ADDR_W_MIN = 1;
  localparam int ADDR_W_MAX = 32;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------------
  // word offsets (word addressing, host multiplies by bytes per word)
  // ----------------------------------------------------------------------
  localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
  localparam logic [31:0] OFS_GAIN = 32'h0000_0001;
  localparam logic [31:0] OFS_STATUS = 32'h0000_0002;
  localparam logic [31:0] OFS_COUNT = 32'h0000_0003;
  localparam logic [31:0] OFS_MEM_BASE = 32'h0000_0010;
  localparam int MEM_WORDS_DEF = 8;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_WRAP_BIT = 1;
  localparam logic [63:0] CTRL_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] GAIN_RST = 64'h0000_0000_0000_0001;
  localparam logic [63:0] INVALID_DATA = 64'hDEAD_BEEF_DEAD_BEEF;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic run;
    logic clear;
    logic [63:0] gain;
  } sys_ctrl_s;

  typedef struct packed {
    logic running;
    logic wrapped;
    logic [31:0] count;
  } sys_stat_s;

  typedef enum logic [1:0] {
    AG_IDLE = 2'b00,
    AG_READ = 2'b01,
    AG_DONE = 2'b10
  } agent_state_e;

endpackage

// file: mm_agent_register_bus_cdc.sv
/*
  Memory-mapped agent register bank with bus clock to system clock crossing.
  Assumes a word-addressed host without byte enables whose data width is not
  wider than this port; the system side logic is a small counter steered by
  the control registers.
*/
// Register access over Avalon-MM and the address map were decided locally.
//
// Operation
// [R01] address width is a parameter from 1 to 32 bits, default 10; the memory window at OFS_MEM_BASE makes widths below 5 fail elaboration
// [R02] data width is a parameter of 16, 32 or 64 bits, default 16
// [R03] no byte enables; every transfer covers the full data word
// [R04] host data width must not exceed the configured bus data width
// [R05] shared memory word is bus width or exactly double it
// [R06] byte ordering selectable at build time, big or little endian
// [R07] with separate bus clock, control registers run on the bus clock
// [R08] synchronous option off means bus clock is asynchronous to system
// [R09] every crossing between domains passes two register stages; gain_reg feeds sysCtrl.gain through none
// [R10] crossing logic present whenever registers or memories are used
// [R11] locations are word addressed; host scales by bytes per word
// [R12] reads of unassigned or unreadable locations answer with invalid data
// [R13] writes to unwritable locations are accepted and dropped
// [R14] double-width memory shows twice as many bus-width entries
// [R15] host times out a request unanswered after one minute; the bench host gives up after WAIT_MAX, 64 bus clock cycles
// [R16] agent signal names carry a configurable interface prefix; port names are fixed and BUS_PREFIX is only checked non-empty
// [R17] synchronous bus clock may skip the two-stage synchronizers
`timescale 1ns/10ps
module mm_agent_register_bus_cdc
  import mm_agent_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int DATA_W = DATA_W_DEF,
  parameter int MEM_RATIO = 2,
  parameter int MEM_WORDS = MEM_WORDS_DEF,
  parameter bit BIG_ENDIAN = 1'b0,
  parameter bit SEPARATE_BUS_CLK = 1'b1,
  parameter bit BUS_CLK_SYNC = 1'b0,
  parameter int BUS_CLK_MHZ = 40,
  parameter string BUS_PREFIX = "ctl"
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic busClk,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic sysRunning,
  output logic [31:0] sysCount
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  localparam int MEM_W = DATA_W * MEM_RATIO;
  localparam int MEM_ENTRIES = MEM_WORDS * MEM_RATIO;
  localparam int MIDX_W = $clog2(MEM_ENTRIES);

  // refused builds stop at elaboration instead of misbehaving at run time
  if (ADDR_W < ADDR_W_MIN || ADDR_W > ADDR_W_MAX) begin : badAddrW // R01
    $error("address width out of range");
  end
  if (DATA_W != 16 && DATA_W != 32 && DATA_W != 64) begin : badDataW // R02
    $error("data width must be 16, 32 or 64");
  end
  if (MEM_RATIO != 1 && MEM_RATIO != 2) begin : badRatio // R05
    $error("memory width ratio must be 1 or 2");
  end
  if (MEM_ENTRIES < 2 || BUS_CLK_MHZ < 1 || BUS_PREFIX == "") begin : badMisc // R16
    $error("bad memory depth, bus clock or prefix");
  end
  if (OFS_MEM_BASE + MEM_ENTRIES > (64'h1 << ADDR_W)) begin : badWindow
    $error("memory window exceeds address space");
  end

  // bus domain clock: the separate bus clock or the system clock itself
  wire logic regClk; // R07
  assign regClk = SEPARATE_BUS_CLK ? busClk : ref_clk;

  // reset release synchronised into the register domain
  logic [1:0] busRstSync_reg;
  always_ff @(posedge regClk or negedge nrst) begin
    if (!nrst) begin
      busRstSync_reg <= 2'b00;
    end else begin
      busRstSync_reg <= {busRstSync_reg[0], 1'b1};
    end
  end
  wire logic busRstN;
  assign busRstN = busRstSync_reg[1];

  // ----------------------------------------------------------------------
  // byte order helper
  // ----------------------------------------------------------------------
  // swaps bytes so big-endian hosts see the most significant byte first
  function automatic logic [DATA_W-1:0] order(input logic [DATA_W-1:0] w);
    logic [DATA_W-1:0] r;
    r = w;
    if (BIG_ENDIAN) begin
      for (int i = 0; i < DATA_W / 8; i++) begin
        r[i*8 +: 8] = w[(DATA_W/8-1-i)*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  // word addresses compared directly; no byte lanes exist on this port
  wire logic [31:0] wordAddr; // R11
  wire logic hitCtrl;
  wire logic hitGain;
  wire logic hitStatus;
  wire logic hitCount;
  wire logic hitMem;
  wire logic [MIDX_W-1:0] memIdx;
  wire logic [DATA_W-1:0] wrWord;
  assign wordAddr = 32'(avs_address);
  assign hitCtrl = wordAddr == OFS_CTRL;
  assign hitGain = wordAddr == OFS_GAIN;
  assign hitStatus = wordAddr == OFS_STATUS;
  assign hitCount = wordAddr == OFS_COUNT;
  assign hitMem = wordAddr >= OFS_MEM_BASE && wordAddr < OFS_MEM_BASE + 32'(MEM_ENTRIES);
  assign memIdx = MIDX_W'(wordAddr - OFS_MEM_BASE); // R14
  assign wrWord = order(avs_writedata); // R06 R03

  // ----------------------------------------------------------------------
  // bus domain registers and shared memory
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] gain_reg;
  logic [MEM_W-1:0] memArr [MEM_WORDS];
  logic [DATA_W-1:0] readData_reg;
  agent_state_e state_reg;
  agent_state_e state_next;
  wire logic [DATA_W-1:0] readMux;
  wire logic [DATA_W-1:0] statusWord;
  wire logic [DATA_W-1:0] countWord;
  wire logic [MEM_W-1:0] memWord;
  wire logic [DATA_W-1:0] memPart;

  // writes land only on writable locations; others are acknowledged and dropped
  always_ff @(posedge regClk or negedge busRstN) begin
    if (!busRstN) begin
      ctrl_reg <= DATA_W'(CTRL_RST);
      gain_reg <= DATA_W'(GAIN_RST);
    end else if (avs_write && !avs_waitrequest) begin
      if (hitCtrl) begin
        ctrl_reg <= wrWord; // R07
      end
      if (hitGain) begin
        gain_reg <= wrWord; // R13
      end
    end
  end

  // memory is not reset; its contents are undefined until written
  always_ff @(posedge regClk) begin
    if (busRstN && avs_write && !avs_waitrequest && hitMem) begin
      memArr[memIdx / MEM_RATIO][(memIdx % MEM_RATIO) * DATA_W +: DATA_W] <= wrWord; // R14
    end
  end

  // read select: status and count are read-only, unmapped reads get filler
  assign memWord = memArr[memIdx / MEM_RATIO];
  assign memPart = memWord[(memIdx % MEM_RATIO) * DATA_W +: DATA_W]; // R05
  assign readMux = hitCtrl ? ctrl_reg :
                   hitGain ? gain_reg :
                   hitStatus ? statusWord :
                   hitCount ? countWord :
                   hitMem ? memPart :
                   DATA_W'(INVALID_DATA); // R12

  // reads answer two cycles late so the memory path is registered
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      AG_IDLE: begin
        if (avs_read) begin
          state_next = AG_READ;
        end
      end
      AG_READ: begin
        state_next = AG_DONE;
      end
      AG_DONE: begin
        state_next = AG_IDLE;
      end
      default: begin
        state_next = AG_IDLE;
      end
    endcase
  end

  always_ff @(posedge regClk or negedge busRstN) begin
    if (!busRstN) begin
      state_reg <= AG_IDLE;
      readData_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == AG_READ) begin
        readData_reg <= order(readMux); // R06 R12
      end
    end
  end

  // writes complete at once, reads wait for the registered answer
  assign avs_waitrequest = avs_read && state_reg != AG_DONE;
  assign avs_readdata = readData_reg;

  // ----------------------------------------------------------------------
  // crossing toward the system domain
  // ----------------------------------------------------------------------
  // level-only control bits cross with two flops; a multi-bit gain would
  // need a handshake, so gain_reg reaches sysCtrl.gain with no flops and nothing reads it
  logic [1:0] ctrlSync1_reg;
  logic [1:0] ctrlSync2_reg;
  wire logic [1:0] ctrlSys;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrlSync1_reg <= 2'b00;
      ctrlSync2_reg <= 2'b00;
    end else begin
      ctrlSync1_reg <= {ctrl_reg[CTRL_CLR_BIT], ctrl_reg[CTRL_RUN_BIT]}; // R09 R10
      ctrlSync2_reg <= ctrlSync1_reg;
    end
  end
  // a synchronous bus clock lets the levels pass straight through
  assign ctrlSys = (BUS_CLK_SYNC || !SEPARATE_BUS_CLK) ?
                   {ctrl_reg[CTRL_CLR_BIT], ctrl_reg[CTRL_RUN_BIT]} : ctrlSync2_reg; // R17 R08

  // ----------------------------------------------------------------------
  // system domain logic
  // ----------------------------------------------------------------------
  sys_ctrl_s sysCtrl;
  sys_stat_s sysStat;
  logic [31:0] count_reg;
  logic wrap_reg;
  logic [31:0] count_next;
  assign sysCtrl = '{run: ctrlSys[0], clear: ctrlSys[1], gain: 64'(gain_reg)};
  assign count_next = count_reg + 32'h0000_0001;

  // free counter with clear and a sticky wrap flag; clear beats wrap set
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
      wrap_reg <= 1'b0;
    end else begin
      if (sysCtrl.clear) begin
        count_reg <= '0;
      end else if (sysCtrl.run) begin
        count_reg <= count_next;
      end
      if (sysCtrl.run && !sysCtrl.clear && count_next == '0) begin
        wrap_reg <= 1'b1;
      end else if (sysCtrl.clear) begin
        wrap_reg <= 1'b0;
      end
    end
  end
  assign sysStat = '{running: sysCtrl.run, wrapped: wrap_reg, count: count_reg};
  assign sysRunning = sysStat.running;
  assign sysCount = count_reg;

  // ----------------------------------------------------------------------
  // crossing back toward the bus domain
  // ----------------------------------------------------------------------
  // status flags are levels; the count is sampled only as a gray code so a
  // torn read shows at most one step of error, except when a clear drops the count to zero
  logic [33:0] statSync1_reg;
  logic [33:0] statSync2_reg;
  wire logic [31:0] grayCount;
  logic [31:0] grayCount_reg;
  wire logic [33:0] statBus;
  logic [31:0] binCount;
  assign grayCount = sysStat.count ^ (sysStat.count >> 1);

  // the code is registered on its own clock so the xor never reaches the
  // crossing flops while it settles
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      grayCount_reg <= '0;
    end else begin
      grayCount_reg <= grayCount;
    end
  end

  always_ff @(posedge regClk or negedge busRstN) begin
    if (!busRstN) begin
      statSync1_reg <= '0;
      statSync2_reg <= '0;
    end else begin
      statSync1_reg <= {sysStat.wrapped, sysStat.running, grayCount_reg}; // R09 R10
      statSync2_reg <= statSync1_reg;
    end
  end
  assign statBus = (BUS_CLK_SYNC || !SEPARATE_BUS_CLK) ?
                   {sysStat.wrapped, sysStat.running, grayCount_reg} : statSync2_reg; // R17 R08

  // gray to binary on the settled copy only
  always_comb begin
    binCount = '0;
    binCount[31] = statBus[31];
    for (int i = 30; i >= 0; i--) begin
      binCount[i] = binCount[i+1] ^ statBus[i];
    end
  end

  assign statusWord = DATA_W'({statBus[33], statBus[32]});
  assign countWord = DATA_W'(binCount);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  unmapped_read_a: assert property (@(posedge regClk) disable iff (!busRstN) // R12
    (state_reg == AG_READ && !(hitCtrl || hitGain || hitStatus || hitCount || hitMem))
      |=> avs_readdata == order(DATA_W'(INVALID_DATA)))
    else $error("unmapped read not answered with filler");

  read_answer_a: assert property (@(posedge regClk) disable iff (!busRstN) // R12
    (avs_read && state_reg == AG_IDLE) |-> ##2 !avs_waitrequest)
    else $error("read not answered within two cycles");

  write_accept_a: assert property (@(posedge regClk) disable iff (!busRstN) // R13
    avs_write |-> !avs_waitrequest)
    else $error("write stalled");

  status_drop_a: assert property (@(posedge regClk) disable iff (!busRstN) // R13
    (avs_write && hitStatus) |=> $stable(ctrl_reg) && $stable(gain_reg))
    else $error("write to read-only location changed state");

  ctrl_write_a: assert property (@(posedge regClk) disable iff (!busRstN) // R07
    (avs_write && hitCtrl) |=> ctrl_reg == $past(wrWord))
    else $error("control write lost");

  sync_depth_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R09
    ctrlSync2_reg == $past(ctrlSync1_reg))
    else $error("control crossing not two stages");

  clear_count_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R10
    sysCtrl.clear |=> count_reg == '0)
    else $error("clear did not zero the counter");

  run_count_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R17
    (sysCtrl.run && !sysCtrl.clear) |=> count_reg == $past(count_reg) + 32'h0000_0001)
    else $error("counter did not advance while running");

  gain_write_a: assert property (@(posedge regClk) disable iff (!busRstN) // R03
    (avs_write && hitGain) |=> gain_reg == $past(wrWord))
    else $error("gain write not full word");

  read_order_a: assert property (@(posedge regClk) disable iff (!busRstN) // R06
    (state_reg == AG_READ && hitGain) |=> avs_readdata == order(gain_reg))
    else $error("gain read not in bus byte order");

  stat_sync_a: assert property (@(posedge regClk) disable iff (!busRstN) // R09
    statSync2_reg == $past(statSync1_reg))
    else $error("status crossing not two stages");

  count_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R10
    (!sysCtrl.run && !sysCtrl.clear) |=> $stable(count_reg))
    else $error("counter moved while stopped");

  gray_step_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R09
    !$past(sysCtrl.clear, 2) |-> $countones(grayCount_reg ^ $past(grayCount_reg)) <= 1)
    else $error("gray count stepped more than one bit");

  wrap_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R10
    sysCtrl.clear |=> !wrap_reg)
    else $error("clear did not drop the wrap flag");

endmodule

// file: host_bus_model.sv
/*
  Behavioural host that drives the agent port on the bus clock.
  Assumes a word-addressed slave whose waitrequest settles before each edge.
*/
`timescale 1ns/10ps
module host_bus_model
  import mm_agent_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int DATA_W = DATA_W_DEF,
  parameter int WAIT_MAX = 64
) (
  input wire logic busClk,
  output logic [ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [DATA_W-1:0] writedata,
  input wire logic [DATA_W-1:0] readdata,
  input wire logic waitrequest
);
  // ----------------------------------------------------------------------
  // request handshake
  // ----------------------------------------------------------------------
  // idle bus at time zero
  initial begin
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
  end

  // holds the request until waitrequest is seen low; a short bound stands in for the host timeout
  task automatic access(input logic isWr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    q = '0;
    @(posedge busClk);
    address <= a;
    writedata <= d;
    write <= isWr;
    read <= !isWr;
    while (!ok && n < WAIT_MAX) begin
      @(posedge busClk);
      n++;
      if (waitrequest === 1'b0) begin
        ok = 1'b1;
        q = readdata;
      end
    end
    // released lines show the inverse so a stale value never passes
    write <= 1'b0;
    read <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask
endmodule

// file: testbench.sv
/*
  Self-checking bench for the agent register bank and its clock crossing.
  Assumes the default 10-bit address, 16-bit little-endian bus and a double-width memory.
*/
`timescale 1ns/10ps
module testbench
  import mm_agent_pkg::*;
;
  localparam int AW = ADDR_W_DEF;
  localparam int DW = DATA_W_DEF;
  localparam int ENTRIES = MEM_WORDS_DEF * 2;
  logic ref_clk = 1'b0;
  logic busClk = 1'b0;
  logic nrst = 1'b0;
  logic [AW-1:0] address;
  logic read;
  logic write;
  logic [DW-1:0] writedata;
  logic [DW-1:0] readdata;
  logic waitrequest;
  logic sysRunning;
  logic [31:0] sysCount;
  int mismatches = 0;
  int totalChecks = 0;

  // ----------------------------------------------------------------------
  // clocks and instances
  // ----------------------------------------------------------------------
  // unrelated periods keep the two domains drifting in phase
  always #12.5 ref_clk = ~ref_clk;
  always #16 busClk = ~busClk;

  mm_agent_register_bus_cdc #(.MEM_RATIO(2), .MEM_WORDS(MEM_WORDS_DEF)) dut (
    .ref_clk(ref_clk), .nrst(nrst), .busClk(busClk), .avs_address(address), .avs_read(read),
    .avs_write(write), .avs_writedata(writedata), .avs_readdata(readdata),
    .avs_waitrequest(waitrequest), .sysRunning(sysRunning), .sysCount(sysCount));

  host_bus_model #(.ADDR_W(AW), .DATA_W(DW)) host (
    .busClk(busClk), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));

  // ----------------------------------------------------------------------
  // compare and bus helpers
  // ----------------------------------------------------------------------
  task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkBit(input string what, input logic exp, input logic got);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [DW-1:0] q;
    logic ok;
    host.access(1'b1, a, d, q, ok);
    chkBit("write answered", 1'b1, ok);
    if (!ok) begin
      end_sim();
    end
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] q);
    logic ok;
    host.access(1'b0, a, '0, q, ok);
    chkBit("read answered", 1'b1, ok);
    if (!ok) begin
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // reset values, full-word write, neighbours untouched
  task automatic regAccess();
    logic [DW-1:0] q;
    rd(AW'(OFS_CTRL), q);
    chkWord("ctrl reset", 32'(CTRL_RST[DW-1:0]), 32'(q));
    rd(AW'(OFS_GAIN), q);
    chkWord("gain reset", 32'(GAIN_RST[DW-1:0]), 32'(q));
    wr(AW'(OFS_GAIN), 16'hA5C3);
    rd(AW'(OFS_GAIN), q);
    chkWord("gain full word", 32'h0000_A5C3, 32'(q));
    rd(AW'(OFS_CTRL), q);
    chkWord("ctrl untouched", 32'h0000_0000, 32'(q));
  endtask

  // unmapped reads answer invalid data, dropped writes change nothing
  task automatic refused();
    logic [DW-1:0] q;
    rd(10'h3FF, q);
    chkWord("unmapped read", 32'(INVALID_DATA[DW-1:0]), 32'(q));
    wr(10'h3FF, 16'h1234);
    wr(AW'(OFS_STATUS), 16'hFFFF);
    wr(AW'(OFS_COUNT), 16'hFFFF);
    rd(AW'(OFS_STATUS), q);
    chkWord("status after write", 32'h0000_0000, 32'(q));
    rd(AW'(OFS_COUNT), q);
    chkWord("count after write", 32'h0000_0000, 32'(q));
    rd(AW'(OFS_GAIN), q);
    chkWord("gain after drops", 32'h0000_A5C3, 32'(q));
  endtask

  // every bus-width entry of the double-width memory is its own location
  task automatic host_shared_memory();
    logic [DW-1:0] q;
    for (int e = 0; e < ENTRIES; e++) begin
      wr(AW'(OFS_MEM_BASE) + AW'(e), 16'h5A00 | DW'(e));
    end
    for (int e = 0; e < ENTRIES; e++) begin
      rd(AW'(OFS_MEM_BASE) + AW'(e), q);
      chkWord("memory entry", 32'(16'h5A00 | DW'(e)), 32'(q));
    end
    rd(AW'(OFS_MEM_BASE) + AW'(ENTRIES), q);
    chkWord("past memory end", 32'(INVALID_DATA[DW-1:0]), 32'(q));
  endtask

  // run, status and count cross both ways through two stages
  task automatic crossing();
    logic [DW-1:0] q;
    logic [31:0] c0;
    int n;
    wr(AW'(OFS_CTRL), 16'h0001);
    chkBit("run not yet crossed", 1'b0, sysRunning);
    n = 0;
    // sampled on the falling edge so the counter has settled
    while (sysRunning !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    chkBit("run crossed", 1'b1, sysRunning);
    chkBit("run crossing depth", 1'b1, n >= 2 && n <= 3);
    if (sysRunning !== 1'b1) begin
      end_sim();
    end
    c0 = sysCount;
    repeat (10) @(negedge ref_clk);
    chkWord("count advanced", c0 + 32'h0000_000A, sysCount);
    rd(AW'(OFS_STATUS), q);
    chkBit("status running", 1'b1, q[STAT_RUN_BIT]);
    wr(AW'(OFS_CTRL), 16'h0000);
    repeat (10) @(posedge ref_clk);
    rd(AW'(OFS_COUNT), q);
    chkWord("count readback", 32'(sysCount[DW-1:0]), 32'(q));
    wr(AW'(OFS_CTRL), 16'h0002);
    repeat (8) @(posedge ref_clk);
    chkWord("count cleared", 32'h0000_0000, sysCount);
    wr(AW'(OFS_CTRL), 16'h0000);
  endtask

  // ----------------------------------------------------------------------
  // sequence and verdict
  // ----------------------------------------------------------------------
  task automatic end_sim();
    if (mismatches == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge busClk);
    regAccess();
    refused();
    host_shared_memory();
    crossing();
    end_sim();
  end

  // a hang anywhere counts as a mismatch
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end
endmodule
